//--- ivr_pkg.sv
package ivr_pkg;

   // Register offsets (byte addresses)
   localparam logic [9:0] IVR_SRC_VEC_BASE = 10'h080;
   localparam logic [9:0] IVR_SRC_VEC_LAST = 10'h0fc;
   localparam logic [9:0] IVR_NORMAL_VEC_OFS = 10'h100;
   localparam logic [9:0] IVR_FAST_VEC_OFS = 10'h104;
   localparam logic [9:0] IVR_STATUS_OFS = 10'h140;
   localparam logic [9:0] IVR_LEVEL_TYPE_OFS = 10'h144;

   // Reset values
   localparam logic [31:0] IVR_VEC_RESET = 32'h0000_0000;
   localparam logic [4:0] IVR_NO_SOURCE = 5'h00;
   localparam logic [31:0] IVR_UNMAPPED_READ = 32'h0000_0000;

   // Number of vector slots
   localparam int IVR_NUM_SRC = 32;

   // Bus request bundle
   typedef struct packed {
      logic read;
      logic write;
      logic [9:0] address;
      logic [31:0] writedata;
   } ivr_req_t;

   // Acknowledge bundle towards the priority logic
   typedef struct packed {
      logic ack;
      logic [4:0] source;
      logic level_clear;
   } ivr_ack_t;

endpackage

//--- ivr_readout.sv
`timescale 1ns/1ns
`default_nettype none
module ivr_readout (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [4:0] cur_irq_num,
   input wire logic cur_irq_valid,
   input wire logic [31:0] fast_vector_value,
   input wire logic normal_request_in,
   output logic normal_request_line,
   output ivr_pkg::ivr_ack_t ack_out
);
   import ivr_pkg::*;

   // Bus phase: a request is first seen, then answered one cycle later
   typedef enum logic {
      IVR_PH_SEE,
      IVR_PH_ANSWER
   } ivr_phase_t;

   // Bus phase state
   ivr_phase_t phase_r;
   ivr_phase_t phase_nxt;

   // Handler slots and level type bits
   logic [31:0] vec_mem_r [IVR_NUM_SRC];
   logic [31:0] level_type_r;
   logic [31:0] level_type_nxt;

   // Registered read data
   logic [31:0] readdata_r;
   logic [31:0] readdata_nxt;

   // Status and request masking
   logic [4:0] last_ack_src_r;
   logic [4:0] last_ack_src_nxt;
   logic ack_count_r;
   logic ack_count_nxt;
   logic masked_r;
   logic masked_nxt;

   // Acknowledge towards the priority logic
   ivr_ack_t ack_r;
   ivr_ack_t ack_nxt;

   // Request bundle and its qualifiers
   ivr_req_t req;
   logic req_active;
   logic req_first;
   logic req_take;
   logic wr_take;
   logic rd_first;

   // Address decode and interrupt state
   logic hit_vec;
   logic hit_normal;
   logic hit_fast;
   logic hit_status;
   logic hit_level;
   logic irq_current;
   logic [31:0] normal_vec;

   // Slot write strobe, index and data
   logic vec_wr_en;
   logic [4:0] vec_wr_slot;
   logic [31:0] vec_wr_data;

   // Slot index from a byte address inside the vector area
   function automatic logic [4:0] slot_of(input logic [9:0] a);
      return a[6:2];
   endfunction

   // Word-aligned address inside the handler slot area
   function automatic logic in_vec_area(input logic [9:0] a);
      return (a >= IVR_SRC_VEC_BASE) && (a <= IVR_SRC_VEC_LAST) && (a[1:0] == 2'b00);
   endfunction

   // Exact match on one register offset
   function automatic logic hit_reg(input logic [9:0] a, input logic [9:0] ofs);
      return a == ofs;
   endfunction

   // Status word: toggle bit above the last acknowledged source
   function automatic logic [31:0] status_word(input logic t, input logic [4:0] s);
      return {26'h0, t, s};
   endfunction

   // Bundle the bus request
   assign req = '{read: avs_read, write: avs_write, address: avs_address,
                  writedata: avs_writedata};

   // Request qualifiers: first edge samples, second edge takes
   assign req_active = req.read | req.write;
   assign req_first = req_active && (phase_r == IVR_PH_SEE);
   assign req_take = req_active && (phase_r == IVR_PH_ANSWER);
   assign wr_take = req.write && req_take;
   assign rd_first = req.read && req_first;

   // Address decode, shared by reads and writes
   assign hit_vec = in_vec_area(req.address);
   assign hit_normal = hit_reg(req.address, IVR_NORMAL_VEC_OFS);
   assign hit_fast = hit_reg(req.address, IVR_FAST_VEC_OFS);
   assign hit_status = hit_reg(req.address, IVR_STATUS_OFS);
   assign hit_level = hit_reg(req.address, IVR_LEVEL_TYPE_OFS);

   // A current interrupt has a valid, non-zero number
   assign irq_current = cur_irq_valid && (cur_irq_num != IVR_NO_SOURCE);

   // Vector of the current source, zero when none is current
   assign normal_vec = irq_current ? vec_mem_r[cur_irq_num] : IVR_VEC_RESET;

   // One wait state, answer on the second edge
   assign avs_waitrequest = req_first;

   // Next bus phase
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         IVR_PH_SEE: begin
            if (req_active) begin
               phase_nxt = IVR_PH_ANSWER;
            end
         end
         IVR_PH_ANSWER: begin
            phase_nxt = IVR_PH_SEE;
         end
         default: begin
            phase_nxt = IVR_PH_SEE;
         end
      endcase
   end

   // Bus phase register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r <= IVR_PH_SEE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // Slot area and level type register are writable; vector registers ignore writes
   assign vec_wr_en = wr_take && hit_vec;
   assign vec_wr_slot = slot_of(req.address);
   assign vec_wr_data = req.writedata;

   // Handler slot storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < IVR_NUM_SRC; i++) begin
            vec_mem_r[i] <= IVR_VEC_RESET;
         end
      end else if (vec_wr_en) begin
         vec_mem_r[vec_wr_slot] <= vec_wr_data;
      end
   end

   // Next level type bits
   always_comb begin
      level_type_nxt = level_type_r;
      if (wr_take && hit_level) begin
         level_type_nxt = req.writedata;
      end
   end

   // Level type register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level_type_r <= IVR_VEC_RESET;
      end else begin
         level_type_r <= level_type_nxt;
      end
   end

   // Read data chosen when the request is first seen
   always_comb begin
      readdata_nxt = readdata_r;
      if (rd_first) begin
         if (hit_vec) begin
            readdata_nxt = vec_mem_r[slot_of(req.address)];
         end else if (hit_normal) begin
            readdata_nxt = normal_vec;
         end else if (hit_fast) begin
            readdata_nxt = fast_vector_value;
         end else if (hit_status) begin
            readdata_nxt = status_word(ack_count_r, last_ack_src_r);
         end else if (hit_level) begin
            readdata_nxt = level_type_r;
         end else begin
            readdata_nxt = IVR_UNMAPPED_READ;
         end
      end
   end

   // Read data register, stands until the next read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         readdata_r <= IVR_UNMAPPED_READ;
      end else begin
         readdata_r <= readdata_nxt;
      end
   end

   // Read data straight from the flip-flops
   assign avs_readdata = readdata_r;

   // Acknowledge on a normal vector read of a current interrupt
   always_comb begin
      ack_nxt.ack = rd_first && hit_normal && irq_current;
      ack_nxt.source = cur_irq_num;
      ack_nxt.level_clear = level_type_r[cur_irq_num];
   end

   // Acknowledge register, one-cycle pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= '0;
      end else begin
         ack_r <= ack_nxt;
      end
   end

   // Clear request only travels with an acknowledge
   assign ack_out = '{ack: ack_r.ack, source: ack_r.source,
                      level_clear: ack_r.ack & ack_r.level_clear};

   // Next status fields
   always_comb begin
      last_ack_src_nxt = last_ack_src_r;
      ack_count_nxt = ack_count_r;
      if (ack_r.ack) begin
         last_ack_src_nxt = ack_r.source;
         ack_count_nxt = ~ack_count_r;
      end
   end

   // Last acknowledged source
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         last_ack_src_r <= IVR_NO_SOURCE;
      end else begin
         last_ack_src_r <= last_ack_src_nxt;
      end
   end

   // Toggle per acknowledge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_count_r <= 1'b0;
      end else begin
         ack_count_r <= ack_count_nxt;
      end
   end

   // Mask set by acknowledge, held until the source request falls
   always_comb begin
      masked_nxt = masked_r;
      if (ack_r.ack) begin
         masked_nxt = 1'b1;
      end else if (!normal_request_in) begin
         masked_nxt = 1'b0;
      end
   end

   // Mask register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         masked_r <= 1'b0;
      end else begin
         masked_r <= masked_nxt;
      end
   end

   // Request line dropped from acknowledge on
   assign normal_request_line = normal_request_in & ~masked_r & ~ack_r.ack;

endmodule
`default_nettype wire

//--- ivr_readout_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ivr_readout_monitor import ivr_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [9:0] avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic [31:0] fast_vector_value,
   input wire logic [4:0] cur_irq_num,
   input wire logic cur_irq_valid,
   input wire logic normal_request_in,
   input wire logic normal_request_line,
   input wire ivr_ack_t ack_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Read of the normal vector register
   wire logic rd_ivr = avs_read && avs_address == IVR_NORMAL_VEC_OFS;
   sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
   // Bus timing, readout and acknowledge
   chk_one_wait: assert property ($rose(avs_read | avs_write) |-> s_one_wait)
      else $error("waitrequest timing wrong");
   chk_ivr_zero: assert property (rd_ivr && !avs_waitrequest && !$past(cur_irq_valid)
      |-> avs_readdata == 32'h0) else $error("vector not zero");
   chk_ack_pulse: assert property (ack_out.ack |=> !ack_out.ack) else $error("ack held");
   chk_ack_cause: assert property (ack_out.ack |-> $past(rd_ivr) && $past(cur_irq_valid))
      else $error("ack without read");
   chk_ack_src: assert property (ack_out.ack |-> ack_out.source == $past(cur_irq_num))
      else $error("ack source wrong");
   chk_req_drop: assert property (ack_out.ack |=> !normal_request_line)
      else $error("request kept");
   chk_req_gate: assert property (!normal_request_in |-> !normal_request_line)
      else $error("request without cause");
   chk_lvl_ack: assert property (ack_out.level_clear |-> ack_out.ack)
      else $error("clear without ack");
   chk_wr_none: assert property ($rose(avs_write) |=> !ack_out.ack [*2])
      else $error("write acked");
endmodule
bind ivr_readout ivr_readout_monitor mon_u (.clk, .arst_n, .avs_read, .avs_write,
   .avs_waitrequest, .avs_address, .avs_writedata, .avs_readdata, .fast_vector_value,
   .cur_irq_num, .cur_irq_valid, .normal_request_in, .normal_request_line, .ack_out);
`default_nettype wire

//--- ivr_prio_model.sv
`timescale 1ns/1ns
`default_nettype none
module ivr_prio_model import ivr_pkg::*; (
   input wire logic clk,
   input wire ivr_ack_t ack_out,
   output logic [4:0] cur_irq_num = IVR_NO_SOURCE,
   output logic cur_irq_valid = 1'b0,
   output logic normal_request_in = 1'b0
);
   // Make one source current
   task raise(input logic [4:0] n);
      @(posedge clk);
      cur_irq_num <= n;
      cur_irq_valid <= 1'b1;
      normal_request_in <= 1'b1;
   endtask
   // Acknowledge retires the current source
   always @(posedge clk) begin
      if (ack_out.ack) begin
         cur_irq_num <= IVR_NO_SOURCE;
         cur_irq_valid <= 1'b0;
         normal_request_in <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import ivr_pkg::*;
   logic clk = 0, arst_n = 0, rd = 0, wr = 0, wait_r, nrl, irq_v, req_in;
   logic [9:0] adr = 0;
   logic [31:0] wd = 0, rdat, q, fv, lt, exp_vec [32];
   logic [4:0] irq_n;
   ivr_ack_t ack;
   int seed = 11, fail_count = 0, checked = 0, n;
   ivr_readout dut_u (.clk, .arst_n, .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_r), .cur_irq_num(irq_n),
      .cur_irq_valid(irq_v), .fast_vector_value(fv), .normal_request_in(req_in),
      .normal_request_line(nrl), .ack_out(ack));
   ivr_prio_model pm_u (.clk, .ack_out(ack), .cur_irq_num(irq_n), .cur_irq_valid(irq_v),
      .normal_request_in(req_in));
   initial begin
      forever #4 clk = ~clk;
   end
   // One bus cycle, held until waitrequest is low
   task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin @(posedge clk); k++; end while (wait_r !== 1'b0 && k < 20);
      if (k >= 20) fail_count++;
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task cmp(input string nm, input logic [31:0] e);
      checked++;
      if (q !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, e, q);
      end
   endtask
   function logic [31:0] exp_ivr(input logic v, input logic [4:0] i);
      return v ? exp_vec[i] : 32'h0;
   endfunction
   task stop_test;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      stop_test;
   end
   // Main sequence
   initial begin
      fv = $random(seed);
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      bus(0, IVR_SRC_VEC_BASE + 10'h14, 0); cmp("slot reset", IVR_VEC_RESET);
      bus(0, IVR_NORMAL_VEC_OFS, 0); cmp("idle vector", exp_ivr(0, 0));
      lt = $random(seed);
      bus(1, IVR_LEVEL_TYPE_OFS, lt);
      bus(0, IVR_LEVEL_TYPE_OFS, 0); cmp("level type", lt);
      for (int i = 1; i < 32; i++) begin
         exp_vec[i] = $random(seed);
         bus(1, IVR_SRC_VEC_BASE + 10'(i * 4), exp_vec[i]);
      end
      for (int i = 1; i < 32; i++) begin
         bus(0, IVR_SRC_VEC_BASE + 10'(i * 4), 0); cmp("slot", exp_vec[i]);
      end
      for (int k = 0; k < 8; k++) begin
         n = k == 0 ? 1 : k == 1 ? 31 : {$random(seed)} % 31 + 1;
         pm_u.raise(5'(n));
         bus(1, IVR_NORMAL_VEC_OFS, $random(seed));
         bus(0, IVR_NORMAL_VEC_OFS, 0); cmp("vector", exp_ivr(1, 5'(n)));
         bus(0, IVR_NORMAL_VEC_OFS, 0); cmp("after ack", exp_ivr(0, 0));
      end
      bus(1, IVR_FAST_VEC_OFS, ~fv);
      bus(0, IVR_FAST_VEC_OFS, 0); cmp("fast vector", fv);
      bus(0, IVR_STATUS_OFS, 0); cmp("status", {26'h0, 1'b0, 5'(n)});
      bus(0, 10'h3fc, 0); cmp("unmapped", IVR_UNMAPPED_READ);
      stop_test;
   end
endmodule
`default_nettype wire
